// ### inc/pic_pkg.sv
// Purpose: Shared constants and types of the priority interrupt controller.
// Assumes: 8-bit register port, one register per address.
// Notes: Source index order is the fixed default priority order.
package pic_pkg;
  // ----------------------------------------
  // Sources
  // ----------------------------------------
  localparam int NUM_SRC = 7;
  localparam int NUM_PIN = 5;
  localparam logic [3:0] SRC_NMI = 4'h7;
  localparam logic [3:0] SRC_WDT = 4'h8;
  localparam logic [3:0] SRC_TRAP = 4'h9;
  localparam logic [3:0] SRC_BRK = 4'hA;
  localparam logic [3:0] SRC_BREAK_BANK_SWITCH_INSTRUCTION = 4'hB;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h09;
  localparam logic [7:0] ADDR_INSVC = 8'h0A;
  localparam logic [7:0] ADDR_CPUCTL = 8'h0B;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_EDGE = 8'h0D;
  localparam logic [7:0] ADDR_PINS = 8'h0E;
  localparam logic [7:0] ADDR_CAP0L = 8'h10;
  localparam logic [7:0] ADDR_CAP0H = 8'h11;
  localparam logic [7:0] ADDR_CAP1L = 8'h12;
  localparam logic [7:0] ADDR_CAP1H = 8'h13;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int CTL_FLAG_BIT = 7;
  localparam int CTL_MASK_BIT = 6;
  localparam int CTL_ISM_BIT = 5;
  localparam int CTL_CSE_BIT = 4;
  localparam logic [7:0] CTL_WR_MASK = 8'hF3;
  localparam int MODE_NEST_BIT = 7;
  localparam int MODE_WDT_FIRST_BIT = 0;
  localparam int CPU_ORIGIN_BIT = 1;
  localparam int STATUS_IE_BIT = 3;
  localparam logic [7:0] CTRL_RST = 8'h43;
  localparam logic [6:0] MASK_RST = 7'h7F;
  localparam logic [7:0] MODE_RST = 8'h80;
  localparam logic [3:0] INSVC_RST = 4'h0;
  localparam logic [7:0] CPUCTL_RST = 8'h00;
  localparam logic [7:0] EDGE_RST = 8'h00;
  localparam logic [1:0] NMI_EDGE_CFG = 2'h1;
  localparam logic [1:0] PRI_LOWEST = 2'h3;
  localparam logic [2:0] LEVEL_IDLE = 3'h4;

  // ----------------------------------------
  // Vectors and macro-service words
  // ----------------------------------------
  localparam logic [15:0] VEC_NMI = 16'h0002;
  localparam logic [15:0] VEC_WDT = 16'h0004;
  localparam logic [15:0] VEC_MASK_BASE = 16'h0006;
  localparam logic [15:0] VEC_TRAP = 16'h003C;
  localparam logic [15:0] VEC_BRK = 16'h003E;
  localparam logic [15:0] VEC_NONE = 16'h0000;
  localparam logic [15:0] ORIGIN_HI = 16'h8000;
  localparam logic [15:0] MACRO_WORD_BASE = 16'hFE06;

  typedef enum logic [1:0] {KIND_VECTOR, KIND_CONTEXT, KIND_MACRO} pic_kind_type;
endpackage : pic_pkg

// ### inc/pic_edge_if.sv
// Purpose: Carries pin levels, edge settings and edge hits between modules.
// Assumes: One bit of level and hit per pin, two bits of setting per pin.
// Notes: Setting bit 0 selects rising, bit 1 falling.
`timescale 1ns/10ps
interface pic_edge_if #(parameter int N = 5);
  logic [N-1:0] pinLevel;
  logic [N-1:0] edgeHit;
  logic [2*N-1:0] edgeCfg;
  modport det (input edgeCfg, output pinLevel, output edgeHit);
  modport ctl (output edgeCfg, input pinLevel, input edgeHit);
endinterface : pic_edge_if

// ### rtl/pic_edge_detect.sv
// Purpose: Synchronises request pins and detects the selected edges.
// Assumes: Pins are asynchronous to clk.
// Notes: Hits are combinational from the second and third stages.
`timescale 1ns/10ps
module pic_edge_detect #(
  parameter int N = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw pins
  input wire logic [N-1:0] pinRaw,
  // Toward the controller
  pic_edge_if.det edge_io
);
  // ----------------------------------------
  // Per-pin synchroniser and edge finder
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      logic meta_r;
      logic sync_r;
      logic prev_r;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          prev_r <= 1'b0;
        end else begin
          meta_r <= pinRaw[g];
          sync_r <= meta_r;
          prev_r <= sync_r;
        end
      end
      assign edge_io.pinLevel[g] = sync_r;
      assign edge_io.edgeHit[g] = (sync_r & ~prev_r & edge_io.edgeCfg[2*g])
                                | (~sync_r & prev_r & edge_io.edgeCfg[2*g+1]);
    end
  endgenerate
endmodule : pic_edge_detect

// ### rtl/pic_controller.sv
// Purpose: Programmable-priority interrupt controller in front of the core.
// Assumes: Timer and core pulses are on clk; pins are asynchronous.
// Notes: One entry per cycle at most, presented for one cycle.
//
// What this block does
// - Seven maskable sources: four pins, three timers
// - Also NMI, watchdog, software traps
// - Software traps unmasked; bank-switch break uses context
// - Default priority order timer0, pins 0-1, timers 1-2, pins 2-3
// - Maskable vectors 0006H-0012H or 8006H-8012H
// - Fixed trap, break vectors; NMI, watchdog vectors follow origin
// - Macro-service words FE06H-FE12H per source
// - Control register: flag, mask, macro, context, priority
// - Request flag shows a received request
// - Either mask bit holds request pending
// - Macro select routes macro; context selects entry
// - Four programmable levels per source
// - Mode register gates level 3 nesting
// - In-service level: hardware written, software read
// - Global enable off blocks software-serviced requests
// - Enable set/cleared by instructions, write, acceptance
// - Pin edges selectable; pins readable when masked
// - Pins 0 and 1 capture free-running timer
// - Accept only strictly higher than current level, or level 3 at level 3 when nesting on
// - Default order breaks ties within a level
// - Context select enters via bank switch
// - Nonmaskables beat maskables; traps first, NMI/watchdog order selectable
`timescale 1ns/10ps
module pic_controller
  import pic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Request sources
  input wire logic timer0OverflowRequest,
  input wire logic timer1MatchRequest,
  input wire logic timer2MatchRequest,
  input wire logic watchdogOverflowRequest,
  input wire logic [3:0] edgeInputPort,
  input wire logic nmiPin,
  input wire logic [15:0] timerValue,
  // Core
  input wire logic enableIrqInstruction,
  input wire logic disableIrqInstruction,
  input wire logic breakInstruction,
  input wire logic breakBankSwitchInstruction,
  input wire logic opcodeTrap,
  input wire logic returnInstruction,
  output logic takeValid,
  output pic_kind_type takeKind,
  output logic [3:0] takeSource,
  output logic [1:0] takeLevel,
  output logic [15:0] takeVector,
  output logic [15:0] macroWord,
  output logic globalIrqEnable
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] ctrl_r [NUM_SRC];
  logic [7:0] ctrl_nxt [NUM_SRC];
  logic [6:0] maskFlagBank_r, maskFlagBank_nxt;
  logic [7:0] irqModeControl_r, irqModeControl_nxt;
  logic [3:0] inServiceLevel_r, inServiceLevel_nxt;
  logic [7:0] cpuCtl_r, cpuCtl_nxt;
  logic [7:0] edgeCfg_r, edgeCfg_nxt;
  logic globalIrqEnable_r, globalIrqEnable_nxt;
  logic nmiPend_r, nmiPend_nxt;
  logic wdtPend_r, wdtPend_nxt;
  logic [15:0] captureReg0_r, captureReg0_nxt;
  logic [15:0] captureReg1_r, captureReg1_nxt;
  logic [7:0] regRdata_r, regRdata_nxt;
  logic takeValid_r, takeValid_nxt;
  pic_kind_type takeKind_r, takeKind_nxt;
  logic [3:0] takeSource_r, takeSource_nxt;
  logic [1:0] takeLevel_r, takeLevel_nxt;
  logic [15:0] takeVector_r, takeVector_nxt;
  logic [15:0] macroWord_r, macroWord_nxt;

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  pic_edge_if #(.N(NUM_PIN)) edgeBus ();
  assign edgeBus.edgeCfg = {NMI_EDGE_CFG, edgeCfg_r};

  pic_edge_detect #(.N(NUM_PIN)) u_edge (
    .clk(clk),
    .rst(rst),
    .pinRaw({nmiPin, edgeInputPort}),
    .edge_io(edgeBus)
  );

  // ----------------------------------------
  // Arbitration terms
  // ----------------------------------------
  logic [6:0] srcSet;
  logic [6:0] effMask;
  logic [6:0] ready, flagBits;
  logic [2:0] curLevel;
  logic [3:0] lowestSvc;
  logic [15:0] origin;
  logic nestOk;

  assign srcSet = {edgeBus.edgeHit[3], edgeBus.edgeHit[2], timer2MatchRequest,
                   timer1MatchRequest, edgeBus.edgeHit[1], edgeBus.edgeHit[0],
                   timer0OverflowRequest};
  // Most urgent in-service level is the lowest set bit
  assign lowestSvc = inServiceLevel_r & (4'(~inServiceLevel_r) + 4'h1);
  assign origin = cpuCtl_r[CPU_ORIGIN_BIT] ? ORIGIN_HI : VEC_NONE;
  assign nestOk = ~irqModeControl_r[MODE_NEST_BIT];

  always_comb begin
    curLevel = LEVEL_IDLE;
    for (int l = 3; l >= 0; l--) begin
      if (inServiceLevel_r[l]) begin
        curLevel = 3'(l);
      end
    end
  end

  generate
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      assign effMask[i] = ctrl_r[i][CTL_MASK_BIT] | maskFlagBank_r[i];
      assign ready[i] = ctrl_r[i][CTL_FLAG_BIT] & ~effMask[i];
      assign flagBits[i] = ctrl_r[i][CTL_FLAG_BIT];
    end
  endgenerate

  logic macroFound, softFound;
  logic [2:0] macroIdx, softIdx;
  logic [1:0] softPri;

  always_comb begin
    macroFound = 1'b0;
    softFound = 1'b0;
    macroIdx = 3'h0;
    softIdx = 3'h0;
    softPri = PRI_LOWEST;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (ready[i] && ctrl_r[i][CTL_ISM_BIT]) begin
        if (!macroFound) begin
          macroFound = 1'b1;
          macroIdx = 3'(i);
        end
      end else if (ready[i] && globalIrqEnable_r
                   && ({1'b0, ctrl_r[i][1:0]} < curLevel
                       || (ctrl_r[i][1:0] == PRI_LOWEST
                           && curLevel == {1'b0, PRI_LOWEST} && nestOk))) begin
        // Strict compare keeps the lower index on a tie
        if (!softFound || ctrl_r[i][1:0] < softPri) begin
          softFound = 1'b1;
          softIdx = 3'(i);
          softPri = ctrl_r[i][1:0];
        end
      end
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic swTrap;
  logic wdtFirst;
  logic takeMask;
  logic [2:0] takeIdx;

  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      ctrl_nxt[i] = ctrl_r[i];
    end
    maskFlagBank_nxt = maskFlagBank_r;
    irqModeControl_nxt = irqModeControl_r;
    inServiceLevel_nxt = inServiceLevel_r;
    cpuCtl_nxt = cpuCtl_r;
    edgeCfg_nxt = edgeCfg_r;
    globalIrqEnable_nxt = globalIrqEnable_r;
    nmiPend_nxt = nmiPend_r;
    wdtPend_nxt = wdtPend_r;
    captureReg0_nxt = captureReg0_r;
    captureReg1_nxt = captureReg1_r;
    regRdata_nxt = 8'h00;
    takeValid_nxt = 1'b0;
    takeKind_nxt = KIND_VECTOR;
    takeSource_nxt = 4'h0;
    takeLevel_nxt = 2'h0;
    takeVector_nxt = VEC_NONE;
    macroWord_nxt = VEC_NONE;
    takeMask = 1'b0;
    takeIdx = 3'h0;
    swTrap = opcodeTrap | breakInstruction | breakBankSwitchInstruction;
    wdtFirst = irqModeControl_r[MODE_WDT_FIRST_BIT];

    // Software access
    if (regWr) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (regAddr == ADDR_CTRL0 + 8'(i)) begin
          ctrl_nxt[i] = regWdata & CTL_WR_MASK;
        end
      end
      unique case (regAddr)
        ADDR_MASK: maskFlagBank_nxt = regWdata[6:0];
        ADDR_MODE: irqModeControl_nxt = regWdata;
        ADDR_CPUCTL: cpuCtl_nxt = regWdata;
        ADDR_STATUS: globalIrqEnable_nxt = regWdata[STATUS_IE_BIT];
        ADDR_EDGE: edgeCfg_nxt = regWdata;
        default: ;
      endcase
    end
    if (regRd) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (regAddr == ADDR_CTRL0 + 8'(i)) begin
          regRdata_nxt = ctrl_r[i];
        end
      end
      unique case (regAddr)
        ADDR_MASK: regRdata_nxt = {1'b0, maskFlagBank_r};
        ADDR_MODE: regRdata_nxt = irqModeControl_r;
        ADDR_INSVC: regRdata_nxt = {4'h0, inServiceLevel_r};
        ADDR_CPUCTL: regRdata_nxt = cpuCtl_r;
        ADDR_STATUS: regRdata_nxt = 8'(globalIrqEnable_r) << STATUS_IE_BIT;
        ADDR_EDGE: regRdata_nxt = edgeCfg_r;
        ADDR_PINS: regRdata_nxt = {3'h0, edgeBus.pinLevel};
        ADDR_CAP0L: regRdata_nxt = captureReg0_r[7:0];
        ADDR_CAP0H: regRdata_nxt = captureReg0_r[15:8];
        ADDR_CAP1L: regRdata_nxt = captureReg1_r[7:0];
        ADDR_CAP1H: regRdata_nxt = captureReg1_r[15:8];
        default: ;
      endcase
    end
    if (enableIrqInstruction) begin
      globalIrqEnable_nxt = 1'b1;
    end
    if (disableIrqInstruction) begin
      globalIrqEnable_nxt = 1'b0;
    end
    if (returnInstruction) begin
      inServiceLevel_nxt = inServiceLevel_r & ~lowestSvc;
    end

    // Acceptance, strongest first
    if (swTrap) begin
      takeValid_nxt = 1'b1;
      if (breakBankSwitchInstruction) begin
        takeKind_nxt = KIND_CONTEXT;
        takeSource_nxt = SRC_BREAK_BANK_SWITCH_INSTRUCTION;
      end else if (breakInstruction) begin
        takeSource_nxt = SRC_BRK;
        takeVector_nxt = VEC_BRK;
      end else begin
        takeSource_nxt = SRC_TRAP;
        takeVector_nxt = VEC_TRAP;
      end
    end else if (nmiPend_r && (!wdtPend_r || !wdtFirst)) begin
      takeValid_nxt = 1'b1;
      takeSource_nxt = SRC_NMI;
      takeVector_nxt = origin | VEC_NMI;
      nmiPend_nxt = 1'b0;
    end else if (wdtPend_r) begin
      takeValid_nxt = 1'b1;
      takeSource_nxt = SRC_WDT;
      takeVector_nxt = origin | VEC_WDT;
      wdtPend_nxt = 1'b0;
    end else if (macroFound) begin
      takeValid_nxt = 1'b1;
      takeMask = 1'b1;
      takeIdx = macroIdx;
      takeKind_nxt = KIND_MACRO;
    end else if (softFound) begin
      takeValid_nxt = 1'b1;
      takeMask = 1'b1;
      takeIdx = softIdx;
      takeKind_nxt = ctrl_r[softIdx][CTL_CSE_BIT] ? KIND_CONTEXT : KIND_VECTOR;
      inServiceLevel_nxt[softPri] = 1'b1;
    end
    if (takeMask) begin
      takeSource_nxt = {1'b0, takeIdx};
      takeLevel_nxt = ctrl_r[takeIdx][1:0];
      takeVector_nxt = origin | (VEC_MASK_BASE + {12'h000, takeIdx, 1'b0});
      macroWord_nxt = MACRO_WORD_BASE + {12'h000, takeIdx, 1'b0};
      ctrl_nxt[takeIdx][CTL_FLAG_BIT] = 1'b0;
    end
    if (takeValid_nxt) begin
      globalIrqEnable_nxt = 1'b0;
    end

    // New events win over any clear in the same cycle
    for (int i = 0; i < NUM_SRC; i++) begin
      if (srcSet[i]) begin
        ctrl_nxt[i][CTL_FLAG_BIT] = 1'b1;
      end
    end
    if (edgeBus.edgeHit[4]) begin
      nmiPend_nxt = 1'b1;
    end
    if (watchdogOverflowRequest) begin
      wdtPend_nxt = 1'b1;
    end
    if (edgeBus.edgeHit[0]) begin
      captureReg0_nxt = timerValue;
    end
    if (edgeBus.edgeHit[1]) begin
      captureReg1_nxt = timerValue;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        ctrl_r[i] <= CTRL_RST;
      end
      maskFlagBank_r <= MASK_RST;
      irqModeControl_r <= MODE_RST;
      inServiceLevel_r <= INSVC_RST;
      cpuCtl_r <= CPUCTL_RST;
      edgeCfg_r <= EDGE_RST;
      globalIrqEnable_r <= 1'b0;
      nmiPend_r <= 1'b0;
      wdtPend_r <= 1'b0;
      captureReg0_r <= 16'h0000;
      captureReg1_r <= 16'h0000;
      regRdata_r <= 8'h00;
      takeValid_r <= 1'b0;
      takeKind_r <= KIND_VECTOR;
      takeSource_r <= 4'h0;
      takeLevel_r <= 2'h0;
      takeVector_r <= VEC_NONE;
      macroWord_r <= VEC_NONE;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        ctrl_r[i] <= ctrl_nxt[i];
      end
      maskFlagBank_r <= maskFlagBank_nxt;
      irqModeControl_r <= irqModeControl_nxt;
      inServiceLevel_r <= inServiceLevel_nxt;
      cpuCtl_r <= cpuCtl_nxt;
      edgeCfg_r <= edgeCfg_nxt;
      globalIrqEnable_r <= globalIrqEnable_nxt;
      nmiPend_r <= nmiPend_nxt;
      wdtPend_r <= wdtPend_nxt;
      captureReg0_r <= captureReg0_nxt;
      captureReg1_r <= captureReg1_nxt;
      regRdata_r <= regRdata_nxt;
      takeValid_r <= takeValid_nxt;
      takeKind_r <= takeKind_nxt;
      takeSource_r <= takeSource_nxt;
      takeLevel_r <= takeLevel_nxt;
      takeVector_r <= takeVector_nxt;
      macroWord_r <= macroWord_nxt;
    end
  end

  assign regRdata = regRdata_r;
  assign takeValid = takeValid_r;
  assign takeKind = takeKind_r;
  assign takeSource = takeSource_r;
  assign takeLevel = takeLevel_r;
  assign takeVector = takeVector_r;
  assign macroWord = macroWord_r;
  assign globalIrqEnable = globalIrqEnable_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic maskTaken;
  assign maskTaken = takeValid_r && takeSource_r < SRC_NMI;

  sequence s_bankBreak;
    breakBankSwitchInstruction ##1 takeValid_r;
  endsequence

  a_bank_break_ctx: assert property (s_bankBreak |-> takeKind_r == KIND_CONTEXT)
    else $error("bank-switch break not entered by context switch");
  a_trap_vector: assert property (opcodeTrap && !breakInstruction
      && !breakBankSwitchInstruction |=> takeVector_r == VEC_TRAP)
    else $error("opcode trap vector wrong");
  a_mask_holds: assert property (maskTaken
      |-> ($past(effMask) & (7'h01 << takeSource_r[2:0])) == 7'h00)
    else $error("masked source was accepted");
  a_enable_gates: assert property (maskTaken && takeKind_r != KIND_MACRO
      |-> $past(globalIrqEnable_r))
    else $error("software service taken with enable off");
  a_accept_disables: assert property (takeValid_r |-> !globalIrqEnable_r)
    else $error("enable not cleared on acceptance");
  a_vector_map: assert property (maskTaken |-> takeVector_r[14:0]
      == VEC_MASK_BASE[14:0] + {11'h000, takeSource_r, 1'b0})
    else $error("maskable vector wrong");
  a_macro_word: assert property (maskTaken && takeKind_r == KIND_MACRO
      |-> macroWord_r == MACRO_WORD_BASE + {11'h000, takeSource_r, 1'b0})
    else $error("macro-service word wrong");
  a_level_strict: assert property (maskTaken && takeKind_r != KIND_MACRO
      |-> {1'b0, takeLevel_r} < $past(curLevel)
          || ($past(nestOk) && takeLevel_r == PRI_LOWEST))
    else $error("request accepted at or below current level");
  a_flag_sets: assert property (|srcSet
      |=> (flagBits & $past(srcSet)) == $past(srcSet))
    else $error("request flag not set by event");
  a_capture_pin0: assert property (edgeBus.edgeHit[0]
      |=> captureReg0_r == $past(timerValue))
    else $error("capture 0 missed timer value");
  a_service_ro: assert property (regWr && regAddr == ADDR_INSVC && !returnInstruction
      && !takeValid_nxt |=> $stable(inServiceLevel_r))
    else $error("in-service level changed by software");
endmodule : pic_controller

// ### verification/pic_core_model.sv
// Purpose: Core side model that returns from each non-macro entry.
// Assumes: Return then enable pulses, one cycle each.
// Notes: Service time is set by serviceCycles, 0 for prompt.
`timescale 1ns/10ps
module pic_core_model
  import pic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Entries from the controller
  input wire logic takeValid,
  input wire pic_kind_type takeKind,
  input wire logic [3:0] serviceCycles,
  // Core pulses
  output logic returnInstruction,
  output logic enableIrqInstruction,
  output logic busy
);
  int cnt;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      returnInstruction <= 1'b0;
      enableIrqInstruction <= 1'b0;
    end else begin
      returnInstruction <= (cnt == 2);
      enableIrqInstruction <= (cnt == 1);
      // Macro service is transparent, no return follows
      if (takeValid && takeKind != KIND_MACRO) begin
        cnt <= serviceCycles + 2;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end

  assign busy = (cnt != 0) || returnInstruction || enableIrqInstruction;
endmodule : pic_core_model

// ### verification/testbench.sv
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: Core model returns and re-enables after each non-macro entry.
// Notes: Expected entries queue in order; any extra entry fails.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench
  import pic_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, pulses = 8'h00;
  logic regWr = 1'b0, regRd = 1'b0, diI = 1'b0;
  logic retI, eiI, busy, takeValid, glbEn, org;
  pic_kind_type takeKind;
  logic [3:0] takeSource, svc = 4'h0, pins = 4'h0;
  logic [1:0] takeLevel;
  logic [15:0] takeVector, macroWord, tval = 16'h0000;
  logic [31:0] seed = 32'hC0FD;
  logic [23:0] expQ[$];
  logic [23:0] e;
  logic [3:0] srcT [5] = '{4'hA, 4'h9, 4'hB, 4'h8, 4'h7};
  logic [15:0] vecT [5] = '{16'h003E, 16'h003C, 16'h0000, 16'h0004, 16'h0002};
  int fails = 0, checks = 0;

  always #5 clk = ~clk;

  pic_controller u_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .timer0OverflowRequest(pulses[0]), .timer1MatchRequest(pulses[1]),
    .timer2MatchRequest(pulses[2]), .watchdogOverflowRequest(pulses[6]),
    .edgeInputPort(pins), .nmiPin(pulses[7]), .timerValue(tval),
    .enableIrqInstruction(eiI), .disableIrqInstruction(diI),
    .breakInstruction(pulses[3]), .breakBankSwitchInstruction(pulses[5]),
    .opcodeTrap(pulses[4]), .returnInstruction(retI), .takeValid(takeValid),
    .takeKind(takeKind), .takeSource(takeSource), .takeLevel(takeLevel),
    .takeVector(takeVector), .macroWord(macroWord), .globalIrqEnable(glbEn));

  pic_core_model u_core (.clk(clk), .rst(rst), .takeValid(takeValid), .takeKind(takeKind),
    .serviceCycles(svc), .returnInstruction(retI), .enableIrqInstruction(eiI), .busy(busy));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [15:0] vecOf(input int i);
    return {org, 15'h0000} | (16'h0006 + 16'(2 * i));
  endfunction : vecOf

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 `CHK("regRdata", x, regRdata)
  endtask : rd

  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    pulses <= m;
    @(posedge clk);
    pulses <= 8'h00;
  endtask : pulse

  task automatic want(input pic_kind_type k, input logic [3:0] s, input logic [15:0] v,
    input logic [1:0] l);
    expQ.push_back({k, s, v, l});
  endtask : want

  task automatic drain();
    int n;
    n = 0;
    while ((expQ.size() != 0 || busy !== 1'b0) && n < 200) begin
      @(posedge clk);
      n++;
    end
    `CHK("pending", 0, expQ.size())
    repeat (4) @(posedge clk);
  endtask : drain

  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // Entry monitor
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst && takeValid === 1'b1) begin
      if (expQ.size() == 0) begin
        `CHK("takeValid", 1'b0, takeValid)
      end else begin
        e = expQ.pop_front();
        `CHK("takeSource", e[21:18], takeSource)
        `CHK("takeKind", e[23:22], takeKind)
        `CHK("takeLevel", e[1:0], takeLevel)
        `CHK("macroWord", e[21:18] < 4'h7 ? 16'hFE06 + {11'h0, e[21:18], 1'b0} : 16'h0000,
          macroWord)
        if (e[23:22] != KIND_MACRO) begin
          `CHK("takeVector", e[17:2], takeVector)
          `CHK("globalIrqEnable", 1'b0, glbEn)
        end
      end
    end
  end

  initial begin
    #200000;
    fails++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    seed = xs(seed);
    org = seed[1];
    svc <= seed[7:4];
    for (int i = 0; i < 7; i++) rd(ADDR_CTRL0 + 8'(i), CTRL_RST);
    rd(ADDR_MASK, 8'h7F);
    rd(ADDR_MODE, MODE_RST);
    wr(ADDR_INSVC, 8'hFF);
    rd(ADDR_INSVC, 8'h00);
    wr(8'h3F, 8'h55);
    rd(8'h3F, 8'h00);
    wr(ADDR_CTRL0 + 8'h06, 8'h0F);
    rd(ADDR_CTRL0 + 8'h06, 8'h03);
    wr(ADDR_CPUCTL, {6'h00, org, 1'b0});
    wr(ADDR_STATUS, 8'h08);
    // Either mask bit holds a request pending
    wr(ADDR_CTRL0, 8'h40);
    wr(ADDR_CTRL0 + 8'h03, 8'h00);
    pulse(8'h03);
    rd(ADDR_CTRL0, 8'hC0);
    rd(ADDR_CTRL0 + 8'h03, 8'h80);
    want(KIND_VECTOR, 4'h3, vecOf(3), 2'h0);
    wr(ADDR_MASK, 8'h00);
    drain();
    want(KIND_VECTOR, 4'h0, vecOf(0), 2'h0);
    wr(ADDR_CTRL0, 8'h80);
    drain();
    rd(ADDR_CTRL0, 8'h00);
    // Level first, default order within a level
    wr(ADDR_CTRL0, 8'h02);
    wr(ADDR_CTRL0 + 8'h03, 8'h01);
    wr(ADDR_CTRL0 + 8'h04, 8'h01);
    want(KIND_VECTOR, 4'h3, vecOf(3), 2'h1);
    want(KIND_VECTOR, 4'h4, vecOf(4), 2'h1);
    want(KIND_VECTOR, 4'h0, vecOf(0), 2'h2);
    pulse(8'h07);
    drain();
    // Macro passes with enable off, vectored waits
    wr(ADDR_CTRL0 + 8'h04, 8'h20);
    wr(ADDR_CTRL0 + 8'h03, 8'h00);
    wr(ADDR_STATUS, 8'h00);
    want(KIND_MACRO, 4'h4, 16'h0000, 2'h0);
    pulse(8'h06);
    drain();
    rd(ADDR_CTRL0 + 8'h03, 8'h80);
    want(KIND_VECTOR, 4'h3, vecOf(3), 2'h0);
    wr(ADDR_STATUS, 8'h08);
    drain();
    wr(ADDR_STATUS, 8'h00);
    for (int k = 0; k < 5; k++) begin
      want(k == 2 ? KIND_CONTEXT : KIND_VECTOR, srcT[k],
        k > 2 ? vecT[k] | {org, 15'h0000} : vecT[k], 2'h0);
      pulse(8'h08 << k);
      drain();
    end
    // Pins: pin0 rising, pin1 falling, pin2 both, pin3 off
    wr(ADDR_STATUS, 8'h08);
    wr(ADDR_EDGE, 8'h39);
    wr(ADDR_CTRL0 + 8'h01, 8'h00);
    wr(ADDR_CTRL0 + 8'h02, 8'h41);
    tval <= seed[31:16];
    pins <= 4'h7;
    want(KIND_VECTOR, 4'h1, vecOf(1), 2'h0);
    drain();
    rd(ADDR_CAP0L, seed[23:16]);
    rd(ADDR_CAP0H, seed[31:24]);
    rd(ADDR_CTRL0 + 8'h02, 8'h41);
    rd(ADDR_CTRL0 + 8'h05, 8'hC3);
    rd(ADDR_PINS, 8'h07);
    wr(ADDR_CTRL0 + 8'h05, 8'h43);
    tval <= seed[15:0];
    pins <= 4'h0;
    repeat (6) @(posedge clk);
    rd(ADDR_CTRL0 + 8'h02, 8'hC1);
    rd(ADDR_CTRL0 + 8'h05, 8'hC3);
    rd(ADDR_CTRL0 + 8'h01, 8'h00);
    rd(ADDR_CAP1L, seed[7:0]);
    rd(ADDR_CAP1H, seed[15:8]);
    rd(ADDR_CAP0H, seed[31:24]);
    rd(ADDR_PINS, 8'h00);
    // Disable instruction clears the global enable
    rd(ADDR_STATUS, 8'h08);
    @(posedge clk) diI <= 1'b1;
    @(posedge clk) diI <= 1'b0;
    rd(ADDR_STATUS, 8'h00);
    stop_test();
  end
endmodule : testbench
